// ==== design/mspwm_top.sv ====
// master/slave pwm pair: period counter, width counter, output stage
`timescale 1ns/1ps
`include "mspwm_params.svh"

module mspwm_top
   import mspwm_pkg::*;
#(
   parameter int CNT_W = `MSPWM_CNT_W,
   parameter int CHANNEL_NUM = 0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // unit enable (peripheral enable register bit)
   input wire logic unit_clock_enable,
   // count clock selection
   input wire mspwm_src_e clk_src_sel,
   input wire logic [`MSPWM_DIV_SEL_W-1:0] prescale_sel,
   // asynchronous clock pins for the sub and low-speed options
   input wire logic sub_clk_pin,
   input wire logic lowspeed_clk_pin,
   // trigger pulses, one core_clk cycle each
   input wire logic channel_start_trigger,
   input wire logic channel_stop_trigger,
   // mode and data
   input wire logic start_irq_enable,
   input wire logic output_polarity_select,
   input wire logic [CNT_W-1:0] master_data_reg,
   input wire logic [CNT_W-1:0] slave_data_reg,
   // counter readback
   output logic [CNT_W-1:0] master_count_reg,
   output logic [CNT_W-1:0] slave_count_reg,
   // interrupt pulses
   output logic master_channel_irq,
   output logic slave_channel_irq,
   // status and waveform
   output logic running,
   output logic pwm_out
);

   // the counter must be wide enough to hold a useful period
   if (CNT_W < 2 || CNT_W > 32) begin : g_chk
      $error("mspwm_top: CNT_W out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // count clock

   localparam bit EXT_OK = (CHANNEL_NUM == `MSPWM_EXT_SRC_CHANNEL); // R2

   logic tick; // one-cycle count clock pulse

   // prescaler runs only while the unit is clocked
   mspwm_prescaler #(
      .DIV_MAX(`MSPWM_DIV_MAX),
      .EXT_ALLOWED(EXT_OK)
   ) u_prescaler (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .enable(unit_clock_enable), // R3
      .div_sel(prescale_sel),
      .src_sel(clk_src_sel),
      .sub_clk_pin(sub_clk_pin),
      .lowspeed_clk_pin(lowspeed_clk_pin),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////
   // helpers

   // value minus one, floored at zero
   function automatic logic [CNT_W-1:0] dec_floor(
      input logic [CNT_W-1:0] v
   );
      dec_floor = (v == '0) ? '0 : v - 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state

   logic run_q, run_d; // counting enabled
   logic [CNT_W-1:0] mcnt_q, mcnt_d; // master down counter
   logic [CNT_W-1:0] scnt_q, scnt_d; // slave down counter
   logic sarm_q, sarm_d; // slave waits for its zero tick
   logic act_q, act_d; // pulse in its active phase
   logic mirq_q, mirq_d; // master interrupt pulse
   logic sirq_q, sirq_d; // slave interrupt pulse
   logic pwm_q, pwm_d; // pin level after polarity

   // period boundary: master already at zero and another tick arrives
   logic m_wrap;
   // slave end: slave already at zero and another tick arrives
   logic s_end;

   ////////////////////////////////////////////////////////////////////
   // next-state logic for the whole pair
   always_comb begin
      run_d = run_q;
      mcnt_d = mcnt_q;
      scnt_d = scnt_q;
      sarm_d = sarm_q;
      act_d = act_q;
      mirq_d = 1'b0;
      sirq_d = 1'b0;
      m_wrap = 1'b0;
      s_end = 1'b0;

      if (!unit_clock_enable) begin
         // unit unclocked: nothing runs and triggers are ignored
         run_d = 1'b0; // R3
         sarm_d = 1'b0;
         act_d = 1'b0;
      end else if (channel_stop_trigger) begin
         // stop wins over a start in the same cycle; counts are kept
         // so software can still read where counting halted
         run_d = 1'b0; // R13
         sarm_d = 1'b0;
         act_d = 1'b0;
      end else if (channel_start_trigger) begin
         // start or restart: load both counters from data
         run_d = 1'b1; // R13
         mcnt_d = master_data_reg;
         scnt_d = dec_floor(slave_data_reg);
         // a zero width never turns the output on
         sarm_d = (slave_data_reg != '0);
         act_d = (slave_data_reg != '0);
         mirq_d = start_irq_enable; // R7
      end else if (run_q && tick) begin
         // master counts down; zero plus one tick ends the period
         if (mcnt_q == `MSPWM_CNT_ZERO) begin
            m_wrap = 1'b1; // R4
         end
         // slave reaches its end on the tick after hitting zero
         if (sarm_q && scnt_q == `MSPWM_CNT_ZERO) begin
            s_end = 1'b1; // R9
         end

         if (m_wrap) begin
            // period boundary: reload both and restart the pulse
            mcnt_d = master_data_reg; // R15
            mirq_d = 1'b1; // R8
            // the slave is loaded one short so the active phase
            // lasts exactly the slave value in ticks
            scnt_d = dec_floor(slave_data_reg); // R5
            sarm_d = (slave_data_reg != '0); // R15
            act_d = (slave_data_reg != '0); // R15
            // a slave end colliding with the boundary still reports
            sirq_d = s_end;
         end else begin
            mcnt_d = mcnt_q - 1'b1; // R4
            if (s_end) begin
               // pulse over: interrupt and fall to inactive
               sirq_d = 1'b1; // R9
               sarm_d = 1'b0;
               act_d = 1'b0; // R15
            end else if (sarm_q) begin
               scnt_d = scnt_q - 1'b1;
            end
         end
      end

      // polarity: active high shows the pulse, active low inverts it,
      // giving a high width of period minus slave value
      pwm_d = run_d & (act_d ^ output_polarity_select); // R5 R6
      if (!run_d) begin
         // idle level follows polarity while the unit is clocked: low for
         // active high and high for active low; with the unit unclocked it is low
         pwm_d = output_polarity_select & ~unit_clock_enable ? 1'b0
            : output_polarity_select;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers for the pair
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         run_q <= 1'b0;
         mcnt_q <= '0;
         scnt_q <= '0;
         sarm_q <= 1'b0;
         act_q <= 1'b0;
         mirq_q <= 1'b0;
         sirq_q <= 1'b0;
         pwm_q <= 1'b0;
      end else begin
         run_q <= run_d;
         mcnt_q <= mcnt_d;
         scnt_q <= scnt_d;
         sarm_q <= sarm_d;
         act_q <= act_d;
         mirq_q <= mirq_d;
         sirq_q <= sirq_d;
         pwm_q <= pwm_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, each straight from a flop

   // live counts, readable any time, also after a stop
   assign master_count_reg = mcnt_q; // R14
   assign slave_count_reg = scnt_q; // R14

   // software reloads data on this pulse so new values land on
   // the next period boundary; data is sampled only at reloads
   assign master_channel_irq = mirq_q;
   assign slave_channel_irq = sirq_q;

   assign running = run_q;
   assign pwm_out = pwm_q;

endmodule

// ==== design/mspwm_params.svh ====
// constants for the master/slave pwm timer pair
//
// Overview of operation
// R1: count clock from fclk down to fclk/2^15
// R2: sub and low-speed clocks on channel 5 only
// R3: unit idles until unit clock enable set
// R4: down counters; period is master value plus one
// R5: active high: high width equals slave value
// R6: active low: high width is period minus slave
// R7: master interrupt when counting starts
// R8: master interrupt one tick after reaching zero
// R9: slave interrupt one tick after reaching zero
// R10: software updates data on master interrupt
// R11: master data rewritten only to change period
// R12: slave data rewritten only to change width
// R13: start and stop by trigger bits
// R14: both count registers readable at all times
// R15: master interrupt reloads; slave interrupt ends pulse
`ifndef MSPWM_PARAMS_SVH
`define MSPWM_PARAMS_SVH

// counter width and zero value
`define MSPWM_CNT_W 16
`define MSPWM_CNT_ZERO 16'h0000
`define MSPWM_CNT_ONE 16'h0001

// prescaler: divide by 2^sel, sel up to this value
`define MSPWM_DIV_MAX 15
`define MSPWM_DIV_SEL_W 4

// only this channel may use the sub or low-speed clock
`define MSPWM_EXT_SRC_CHANNEL 5

`endif

// ==== design/mspwm_pkg.sv ====
// types shared by the master/slave pwm timer pair
package mspwm_pkg;

   // count clock source selection
   typedef enum logic [1:0] {
      MSPWM_SRC_PRESCALED = 2'b00,
      MSPWM_SRC_SUB = 2'b01,
      MSPWM_SRC_LOWSPEED = 2'b10
   } mspwm_src_e;

endpackage

// ==== design/mspwm_prescaler.sv ====
// count clock generator: prescaler plus external clock edge ticks
`timescale 1ns/1ps
`include "mspwm_params.svh"

module mspwm_prescaler
   import mspwm_pkg::*;
#(
   parameter int DIV_MAX = `MSPWM_DIV_MAX,
   parameter bit EXT_ALLOWED = 1'b0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // control
   input wire logic enable,
   input wire logic [`MSPWM_DIV_SEL_W-1:0] div_sel,
   input wire mspwm_src_e src_sel,
   // asynchronous clock pins
   input wire logic sub_clk_pin,
   input wire logic lowspeed_clk_pin,
   // one-cycle count clock tick
   output logic tick
);

   // select field must reach every divide setting
   if (DIV_MAX >= (1 << `MSPWM_DIV_SEL_W) || DIV_MAX < 1) begin : g_chk
      $error("mspwm_prescaler: DIV_MAX out of range");
   end

   logic [DIV_MAX-1:0] div_q, div_d; // free prescale counter
   logic [2:0] sub_q, sub_d; // sync pair plus edge stage
   logic [2:0] ls_q, ls_d; // sync pair plus edge stage
   logic tick_q, tick_d; // registered tick
   logic [DIV_MAX-1:0] mask; // low bits that must all be ones

   ////////////////////////////////////////////////////////////////////
   // next values; the edge stage reads only the second sync flop
   always_comb begin
      div_d = enable ? div_q + 1'b1 : '0;
      sub_d = {sub_q[1], sub_q[0], sub_clk_pin};
      ls_d = {ls_q[1], ls_q[0], lowspeed_clk_pin};
      mask = '0;
      for (int i = 0; i < DIV_MAX; i++) begin
         if (i < int'(div_sel)) begin
            mask[i] = 1'b1;
         end
      end
      tick_d = 1'b0;
      if (enable) begin
         // external sources only where the channel permits R2
         if (EXT_ALLOWED && src_sel == MSPWM_SRC_SUB) begin
            tick_d = sub_q[1] & ~sub_q[2]; // R1
         end else if (EXT_ALLOWED && src_sel == MSPWM_SRC_LOWSPEED) begin
            tick_d = ls_q[1] & ~ls_q[2]; // R1
         end else begin
            // fclk/2^sel: tick when selected low bits are all ones
            tick_d = ((div_q & mask) == mask); // R1
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_q <= '0;
         sub_q <= 3'h0;
         ls_q <= 3'h0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         sub_q <= sub_d;
         ls_q <= ls_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule

// ==== test/mspwm_checker.sv ====
// assertion checker for the master/slave pwm pair
`timescale 1ns/1ps
module mspwm_checker #(parameter int CNT_W = 16) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // controls
   input wire logic unit_clock_enable,
   input wire logic channel_start_trigger,
   input wire logic channel_stop_trigger,
   input wire logic start_irq_enable,
   input wire logic output_polarity_select,
   input wire logic [CNT_W-1:0] master_data_reg,
   input wire logic [CNT_W-1:0] slave_data_reg,
   // observed outputs
   input wire logic [CNT_W-1:0] master_count_reg,
   input wire logic [CNT_W-1:0] slave_count_reg,
   input wire logic master_channel_irq,
   input wire logic slave_channel_irq,
   input wire logic running,
   input wire logic pwm_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic go; // accepted start, stop wins a tie
   assign go = unit_clock_enable & channel_start_trigger
      & ~channel_stop_trigger;
   //////////////////////////////////////////////////////////////
   // polarity is compared as it stood when the flop was loaded,
   // since the bench may move it right after a stop
   AST_EN_OFF: assert property (
      !unit_clock_enable |=> !running && !pwm_out)
      else $error("unit off but still active");
   AST_START: assert property (
      go |=> running && master_count_reg == $past(master_data_reg))
      else $error("start not taken with period load");
   AST_STOP: assert property (
      unit_clock_enable && channel_stop_trigger |=> !running
      && pwm_out == $past(output_polarity_select))
      else $error("stop not taken");
   AST_START_IRQ: assert property (
      go && start_irq_enable |=> master_channel_irq)
      else $error("no irq at start");
   AST_ACTIVE: assert property (
      go && slave_data_reg != '0
      |=> pwm_out != $past(output_polarity_select))
      else $error("output not active after start");
   AST_WRAP: assert property (
      master_channel_irq && running && !$past(go)
      |-> $past(master_count_reg) == '0
      && master_count_reg == $past(master_data_reg))
      else $error("master irq not at zero reload");
   AST_SIRQ: assert property (
      slave_channel_irq && running && !$past(go) && !master_channel_irq
      |-> $past(slave_count_reg) == '0
      && pwm_out == $past(output_polarity_select))
      else $error("slave irq not at zero end");
   AST_DOWN: assert property (
      running && $past(running) && !$past(go) && !master_channel_irq
      && master_count_reg != $past(master_count_reg)
      |-> master_count_reg == $past(master_count_reg) - 1'h1)
      else $error("master count not down by one");
   AST_FROZEN: assert property (
      !running && $past(!running) && unit_clock_enable
      && $past(unit_clock_enable)
      |-> $stable(master_count_reg) && $stable(slave_count_reg))
      else $error("counts move while stopped");
   // main scenarios reached
   COV_WRAP: cover property (master_channel_irq && running);
   COV_SLAVE: cover property (slave_channel_irq);
   COV_START_IRQ: cover property (go && start_irq_enable);
endmodule
bind mspwm_top mspwm_checker #(.CNT_W(CNT_W)) u_chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .unit_clock_enable(unit_clock_enable),
   .channel_start_trigger(channel_start_trigger),
   .channel_stop_trigger(channel_stop_trigger),
   .start_irq_enable(start_irq_enable),
   .output_polarity_select(output_polarity_select),
   .master_data_reg(master_data_reg), .slave_data_reg(slave_data_reg),
   .master_count_reg(master_count_reg), .slave_count_reg(slave_count_reg),
   .master_channel_irq(master_channel_irq),
   .slave_channel_irq(slave_channel_irq), .running(running),
   .pwm_out(pwm_out));

// ==== test/mspwm_top_tb_top.sv ====
// self-checking bench for the master/slave pwm pair
`timescale 1ns/1ps
module mspwm_top_tb_top;
   import mspwm_pkg::*;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic en = 1'h1, st = 1'h0, sp = 1'h0, ie = 1'h0, pol = 1'h0;
   logic [3:0] psel = 4'h0;
   logic [15:0] m = 16'h3, s = 16'h1, mc, sc;
   logic mi, si, run, pwm;
   logic [15:0] mc5, sc5; // channel 5 readback
   logic mi5, si5, run5, pwm5; // channel 5 irqs and waveform
   logic sbp = 1'h0, lsp = 1'h0; // slow clock pins
   mspwm_src_e src = MSPWM_SRC_PRESCALED;
   // slow pin periods in core_clk cycles; sub is twice low-speed
   localparam int LS_P = 4;
   localparam int SUB_P = 2 * LS_P;
   int fails = 0, cmp_count = 0, n, h, e;
   // row: polarity, prescale, period value, width value, start irq
   typedef struct {
      logic p;
      logic [3:0] k;
      logic [15:0] m, s;
      logic i;
   } mspwm_row_s;
   mspwm_row_s rows [6] = '{'{0,0,3,1,1}, '{1,0,3,1,0}, '{0,1,5,2,0},
      '{1,2,2,2,1}, '{0,0,4,0,0}, '{0,0,2,5,0}};
   // channel 0: pin sources must be ignored here
   mspwm_top #(.CNT_W(16), .CHANNEL_NUM(0)) uut (.core_clk(core_clk),
      .sys_rst(sys_rst), .unit_clock_enable(en),
      .clk_src_sel(src), .prescale_sel(psel),
      .sub_clk_pin(sbp), .lowspeed_clk_pin(lsp),
      .channel_start_trigger(st), .channel_stop_trigger(sp),
      .start_irq_enable(ie), .output_polarity_select(pol),
      .master_data_reg(m), .slave_data_reg(s), .master_count_reg(mc),
      .slave_count_reg(sc), .master_channel_irq(mi),
      .slave_channel_irq(si), .running(run), .pwm_out(pwm));
   // second pair on the one channel that may count on the pins
   mspwm_top #(.CNT_W(16), .CHANNEL_NUM(5)) uut5 (.core_clk(core_clk),
      .sys_rst(sys_rst), .unit_clock_enable(en),
      .clk_src_sel(src), .prescale_sel(psel),
      .sub_clk_pin(sbp), .lowspeed_clk_pin(lsp),
      .channel_start_trigger(st), .channel_stop_trigger(sp),
      .start_irq_enable(ie), .output_polarity_select(pol),
      .master_data_reg(m), .slave_data_reg(s), .master_count_reg(mc5),
      .slave_count_reg(sc5), .master_channel_irq(mi5),
      .slave_channel_irq(si5), .running(run5), .pwm_out(pwm5));
   //////////////////////////////////////////////////////////////
   always #50 core_clk = ~core_clk;
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // step k edges, land just after the last one
   task automatic cyc(input int k = 1);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // one period, wrap to wrap: cycles and high cycles of a pair
   task automatic span(input logic c5, output int np, output int nh);
      np = 0;
      nh = 0;
      do begin
         np++;
         nh += ((c5 ? pwm5 : pwm) === 1'h1);
         cyc();
      end while ((c5 ? mi5 : mi) !== 1'h1 && np < 5000);
   endtask
   // slow clock pins, moved just after a core_clk edge
   always begin
      cyc(LS_P / 2);
      lsp = ~lsp;
      cyc(LS_P / 2);
      lsp = ~lsp;
      sbp = ~sbp;
   end
   // one-cycle trigger pulse; returns in the answer cycle
   task automatic trig(input logic a, input logic b);
      st = a;
      sp = b;
      cyc();
      st = 1'h0;
      sp = 1'h0;
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////
   // watchdog, far beyond the few hundred cycles needed
   initial begin
      #2000000;
      fails++;
      close_out();
   end
   initial begin
      cyc(6);
      chk({run, pwm, mi, si, mc}, 0);
      chk(sc, 0);
      chk({run5, pwm5, mi5, si5, mc5}, 0);
      chk(sc5, 0);
      sys_rst = 1'h0;
      cyc();
      foreach (rows[r]) begin
         pol = rows[r].p;
         psel = rows[r].k;
         m = rows[r].m;
         s = rows[r].s;
         ie = rows[r].i;
         cyc(2);
         trig(1'h1, 1'h0);
         chk({run, mi}, {1'h1, ie});
         chk(mc, m);
         chk(sc, (s != 16'h0) ? s - 16'h1 : 16'h0);
         // skip to a wrap, then measure one whole period
         span(1'h0, n, h);
         span(1'h0, n, h);
         e = (s > m) ? m + 1 : s;
         if (pol) begin
            e = m + 1 - e;
         end
         chk(n, (m + 1) << psel);
         chk(h, e << psel);
         trig(1'h0, 1'h1);
         chk({run, pwm}, {1'h0, pol});
      end
      // pin sources: counted only on channel 5, prescaled elsewhere
      pol = 1'h0;
      psel = 4'h1;
      m = 16'h3;
      s = 16'h1;
      src = MSPWM_SRC_SUB;
      cyc(2);
      trig(1'h1, 1'h0);
      span(1'h0, n, h);
      span(1'h0, n, h);
      chk(n, (m + 1) << psel);
      chk(h, s << psel);
      span(1'h1, n, h);
      span(1'h1, n, h);
      chk(n, (m + 1) * SUB_P);
      chk(h, s * SUB_P);
      src = MSPWM_SRC_LOWSPEED;
      span(1'h1, n, h);
      span(1'h1, n, h);
      chk(n, (m + 1) * LS_P);
      chk(h, s * LS_P);
      trig(1'h0, 1'h1);
      src = MSPWM_SRC_PRESCALED;
      // data written on a master irq takes effect at the next wrap
      psel = 4'h0;
      cyc();
      trig(1'h1, 1'h0);
      span(1'h0, n, h);
      m = 16'h5;
      s = 16'h3;
      span(1'h0, n, h);
      chk(n, 4);
      chk(h, 1);
      span(1'h0, n, h);
      chk(n, 6);
      chk(h, 3);
      cyc(3);
      chk({si, pwm, sc}, {1'h1, 1'h0, 16'h0});
      trig(1'h0, 1'h1);
      cyc();
      // stop wins over a start in the same cycle
      trig(1'h1, 1'h1);
      chk(run, 0);
      // triggers ignored while the unit clock is off
      en = 1'h0;
      cyc();
      trig(1'h1, 1'h0);
      chk({run, pwm}, 0);
      en = 1'h1;
      cyc();
      // restart mid period reloads the period count
      trig(1'h1, 1'h0);
      cyc(2);
      trig(1'h1, 1'h0);
      chk(mc, m);
      // reset in mid run clears everything, active low this time
      pol = 1'h1;
      sys_rst = 1'h1;
      cyc(2);
      chk({run, pwm, mi, mc}, 0);
      sys_rst = 1'h0;
      cyc();
      // stopped and enabled: pin rests at the inactive level
      chk({run, pwm}, {1'h0, pol});
      // a start right after release is taken
      trig(1'h1, 1'h0);
      chk(run, 1);
      close_out();
   end
endmodule
